// ### verilog/mmd_consts.svh
`ifndef MMD_CONSTS_SVH
`define MMD_CONSTS_SVH

// ----------------------------------------
// Code flash regions
// ----------------------------------------
`define MMD_RESET_VEC 20'h00000
`define MMD_VEC_HI 20'h0007F
`define MMD_TABLE_CALL_INSTRUCTION_LO 20'h00080
`define MMD_TABLE_CALL_INSTRUCTION_HI 20'h000BF
`define MMD_OPT_LO 20'h000C0
`define MMD_OPT_HI 20'h000C3
`define MMD_SECID_LO 20'h000C4
`define MMD_SECID_HI 20'h000CD
`define MMD_FLASH_TOP_SMALL 20'h01FFF
`define MMD_FLASH_TOP_LARGE 20'h03FFF

// ----------------------------------------
// Upper address space
// ----------------------------------------
`define MMD_MIRROR_LO 20'hF0000
`define MMD_SFR2_HI 20'hF07FF
`define MMD_RAM_LO 20'hFF900
`define MMD_GPR_LO 20'hFFEE0
`define MMD_SFR_LO 20'hFFF00
`define MMD_PMC_ADDR 20'hFFFFE

// ----------------------------------------
// Mirror control register
// ----------------------------------------
`define MMD_PMC_RESET 8'h00
`define MMD_MAA_BIT 0

`endif

// ### verilog/mmd_pkg.sv
package mmd_pkg;

  typedef enum logic [3:0] {
    RG_NONE = 4'h0,
    RG_VECTOR = 4'h1,
    RG_TABLE_CALL_INSTRUCTION = 4'h2,
    RG_OPTION = 4'h3,
    RG_SECID = 4'h4,
    RG_FLASH = 4'h5,
    RG_MIRROR = 4'h6,
    RG_RAM = 4'h7,
    RG_GPR = 4'h8,
    RG_SFR = 4'h9,
    RG_PMC = 4'hA
  } mmd_region_t;

  typedef enum logic [4:0] {
    ST_BOOT = 5'h01,
    ST_IDLE = 5'h02,
    ST_WAIT = 5'h04,
    ST_CAPTURE = 5'h08,
    ST_RESP = 5'h10
  } mmd_state_t;

  typedef enum logic [1:0] {
    SRC_BOOT = 2'h0,
    SRC_FETCH = 2'h1,
    SRC_DATA = 2'h2,
    SRC_TBL = 2'h3
  } mmd_src_t;

  typedef struct packed {
    mmd_state_t state;
    mmd_src_t src;
    mmd_region_t target;
    logic hi;
    logic [19:0] addr;
    logic [7:0] low;
    logic flash_en;
    logic [13:0] flash_addr;
    logic ram_en;
    logic [10:0] ram_addr;
    logic gpr_sel;
    logic [1:0] gpr_bank;
    logic sfr_en;
    logic [7:0] sfr_addr;
    logic mem_we;
    logic [7:0] mem_wdata;
    logic mem_bit_op;
    logic [2:0] mem_bit_idx;
    logic fetch_ack;
    logic fetch_fault;
    logic [7:0] fetch_rdata;
    logic data_ack;
    logic data_fault;
    logic [7:0] data_rdata;
    logic tbl_ack;
    logic tbl_fault;
    logic [19:0] tbl_target;
    logic boot_done;
    logic [19:0] boot_pc;
  } mmd_top_state_t;

  typedef struct packed {
    logic mirror_area_select;
  } mmd_mirror_state_t;

endpackage

// ### verilog/mmd_dec_if.sv
`timescale 1ns/1ps
interface mmd_dec_if;
  import mmd_pkg::*;
  logic [19:0] addr;
  mmd_region_t region;
  logic [13:0] flash_off;
  logic [10:0] ram_off;
  logic fetch_ok;
  logic rd_ok;
  logic wr_ok;
  modport decoder(input addr, output region, flash_off, ram_off, fetch_ok, rd_ok, wr_ok);
  modport user(output addr, input region, flash_off, ram_off, fetch_ok, rd_ok, wr_ok);
endinterface

// ### verilog/mmd_region_decode.sv
`timescale 1ns/1ps
`include "mmd_consts.svh"
module mmd_region_decode
  import mmd_pkg::*;
#(
  parameter bit FLASH_LARGE = 1'h1
) (
  input wire logic mirror_area_select,
  mmd_dec_if.decoder dec
);

  localparam logic [19:0] FLASH_TOP = FLASH_LARGE ? `MMD_FLASH_TOP_LARGE : `MMD_FLASH_TOP_SMALL;

  // ----------------------------------------
  // Address classification
  // ----------------------------------------
  function automatic mmd_region_t mmd_classify(input logic [19:0] a, input logic m);
    logic [19:0] off;
    off = a - `MMD_MIRROR_LO;
    if (a == `MMD_PMC_ADDR) begin
      return RG_PMC;
    end else if (a >= `MMD_SFR_LO) begin
      return RG_SFR;
    end else if (a >= `MMD_GPR_LO) begin
      return RG_GPR;
    end else if (a >= `MMD_RAM_LO) begin
      return RG_RAM;
    end else if (a >= `MMD_MIRROR_LO) begin
      // Second register area and prohibited gaps are never shown as flash
      if (a <= `MMD_SFR2_HI || m || off > FLASH_TOP) begin
        return RG_NONE;
      end else begin
        return RG_MIRROR;
      end
    end else if (a <= `MMD_VEC_HI) begin
      return RG_VECTOR;
    end else if (a <= `MMD_TABLE_CALL_INSTRUCTION_HI) begin
      return RG_TABLE_CALL_INSTRUCTION;
    end else if (a <= `MMD_OPT_HI) begin
      return RG_OPTION;
    end else if (a <= `MMD_SECID_HI) begin
      return RG_SECID;
    end else if (a <= FLASH_TOP) begin
      return RG_FLASH;
    end else begin
      return RG_NONE;
    end
  endfunction

  logic [19:0] mirror_off;

  assign mirror_off = dec.addr - `MMD_MIRROR_LO;
  assign dec.region = mmd_classify(dec.addr, mirror_area_select);
  assign dec.flash_off = (dec.region == RG_MIRROR) ? mirror_off[13:0] : dec.addr[13:0];
  assign dec.ram_off = 11'(dec.addr - `MMD_RAM_LO);
  // Mirror and register banks are not executable
  assign dec.fetch_ok = !(dec.region inside {RG_NONE, RG_MIRROR, RG_GPR, RG_SFR, RG_PMC});
  assign dec.rd_ok = (dec.region != RG_NONE);
  assign dec.wr_ok = dec.region inside {RG_RAM, RG_GPR, RG_SFR, RG_PMC};

endmodule

// ### verilog/mmd_mirror_ctrl.sv
`timescale 1ns/1ps
`include "mmd_consts.svh"
module mmd_mirror_ctrl
  import mmd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic bit_op,
  input wire logic [2:0] bit_idx,
  input wire logic [7:0] wdata,
  output logic [7:0] ctrl_value,
  output logic mirror_area_select
);

  mmd_mirror_state_t st_r;
  mmd_mirror_state_t st_nxt;

  // ----------------------------------------
  // Byte or single-bit update
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (wr_en) begin
      if (!bit_op) begin
        st_nxt.mirror_area_select = wdata[`MMD_MAA_BIT];
      end else if (bit_idx == 3'(`MMD_MAA_BIT)) begin
        st_nxt.mirror_area_select = wdata[0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r.mirror_area_select <= 1'(`MMD_PMC_RESET);
    end else begin
      st_r <= st_nxt;
    end
  end

  // Upper bits are reserved and read as zero
  assign ctrl_value = {7'h00, st_r.mirror_area_select};
  assign mirror_area_select = st_r.mirror_area_select;

endmodule

// ### verilog/mmd_memory_map_decoder.sv
`timescale 1ns/1ps
`include "mmd_consts.svh"
module mmd_memory_map_decoder
  import mmd_pkg::*;
#(
  parameter bit FLASH_LARGE = 1'h1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic fetch_req,
  input wire logic [19:0] fetch_addr,
  input wire logic data_req,
  input wire logic data_we,
  input wire logic data_bit_op,
  input wire logic [2:0] data_bit_idx,
  input wire logic [19:0] data_addr,
  input wire logic [7:0] data_wdata,
  input wire logic tbl_req,
  input wire logic [7:0] tbl_addr,
  input wire logic [7:0] flash_rdata,
  input wire logic [7:0] ram_rdata,
  input wire logic [7:0] sfr_rdata,
  output logic fetch_ack,
  output logic fetch_fault,
  output logic [7:0] fetch_rdata,
  output logic data_ack,
  output logic data_fault,
  output logic [7:0] data_rdata,
  output logic tbl_ack,
  output logic tbl_fault,
  output logic [19:0] tbl_target,
  output logic boot_done,
  output logic [19:0] boot_pc,
  output logic flash_en,
  output logic [13:0] flash_addr,
  output logic ram_en,
  output logic [10:0] ram_addr,
  output logic gpr_sel,
  output logic [1:0] gpr_bank,
  output logic sfr_en,
  output logic [7:0] sfr_addr,
  output logic mem_we,
  output logic [7:0] mem_wdata,
  output logic mem_bit_op,
  output logic [2:0] mem_bit_idx
);

  localparam mmd_top_state_t RESET_STATE = '{
    state: ST_BOOT,
    src: SRC_BOOT,
    target: RG_VECTOR,
    default: '0
  };

  mmd_top_state_t st_r;
  mmd_top_state_t st_nxt;
  logic pmc_wr;
  logic [7:0] pmc_value;
  logic mirror_area_select;
  logic [7:0] cap_byte;

  mmd_dec_if fetch_dec ();
  mmd_dec_if data_dec ();

  // ----------------------------------------
  // Address decoders and mirror control
  // ----------------------------------------
  assign fetch_dec.addr = fetch_addr;
  assign data_dec.addr = data_addr;

  mmd_region_decode #(
    .FLASH_LARGE(FLASH_LARGE)
  ) u_fetch_decode (
    .mirror_area_select(mirror_area_select),
    .dec(fetch_dec)
  );

  mmd_region_decode #(
    .FLASH_LARGE(FLASH_LARGE)
  ) u_data_decode (
    .mirror_area_select(mirror_area_select),
    .dec(data_dec)
  );

  mmd_mirror_ctrl u_mirror_ctrl (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(pmc_wr),
    .bit_op(data_bit_op),
    .bit_idx(data_bit_idx),
    .wdata(data_wdata),
    .ctrl_value(pmc_value),
    .mirror_area_select(mirror_area_select)
  );

  // ----------------------------------------
  // Strobe one memory for an access
  // ----------------------------------------
  function automatic mmd_top_state_t mmd_issue(
    input mmd_top_state_t s,
    input mmd_region_t rg,
    input logic [19:0] a,
    input logic [13:0] fo,
    input logic [10:0] ro
  );
    mmd_top_state_t t;
    t = s;
    t.target = rg;
    t.addr = a;
    t.state = ST_WAIT;
    case (rg)
      RG_RAM, RG_GPR: begin
        t.ram_en = 1'h1;
        t.ram_addr = ro;
        t.gpr_sel = (rg == RG_GPR);
        t.gpr_bank = a[4:3];
      end
      RG_SFR: begin
        t.sfr_en = 1'h1;
        t.sfr_addr = a[7:0];
      end
      default: begin
        t.flash_en = 1'h1;
        t.flash_addr = fo;
      end
    endcase
    return t;
  endfunction

  // ----------------------------------------
  // Returned byte by target
  // ----------------------------------------
  always_comb begin
    case (st_r.target)
      RG_RAM, RG_GPR: cap_byte = ram_rdata;
      RG_SFR: cap_byte = sfr_rdata;
      default: cap_byte = flash_rdata;
    endcase
  end

  // ----------------------------------------
  // Access sequencer
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    pmc_wr = 1'h0;
    st_nxt.flash_en = 1'h0;
    st_nxt.ram_en = 1'h0;
    st_nxt.sfr_en = 1'h0;
    st_nxt.mem_we = 1'h0;
    st_nxt.fetch_ack = 1'h0;
    st_nxt.data_ack = 1'h0;
    st_nxt.tbl_ack = 1'h0;
    case (st_r.state)
      ST_BOOT: begin
        st_nxt.hi = 1'h0;
        st_nxt.src = SRC_BOOT;
        st_nxt = mmd_issue(st_nxt, RG_VECTOR, `MMD_RESET_VEC, 14'(`MMD_RESET_VEC), 11'h000);
      end
      ST_IDLE: begin
        st_nxt.hi = 1'h0;
        if (tbl_req) begin
          st_nxt.src = SRC_TBL;
          st_nxt.tbl_fault = 1'h0;
          // Only the vector and table-call areas, on word boundaries
          if ({12'h000, tbl_addr} > `MMD_TABLE_CALL_INSTRUCTION_HI || tbl_addr[0]) begin
            st_nxt.tbl_ack = 1'h1;
            st_nxt.tbl_fault = 1'h1;
            st_nxt.state = ST_RESP;
          end else begin
            st_nxt = mmd_issue(st_nxt, RG_VECTOR, {12'h000, tbl_addr},
                               {6'h00, tbl_addr}, 11'h000);
          end
        end else if (data_req) begin
          st_nxt.src = SRC_DATA;
          // Write flag rides in hi, since the mem_we pulse is gone by capture
          st_nxt.hi = data_we;
          st_nxt.data_fault = 1'h0;
          st_nxt.mem_wdata = data_wdata;
          st_nxt.mem_bit_op = data_bit_op;
          st_nxt.mem_bit_idx = data_bit_idx;
          if (data_we ? !data_dec.wr_ok : !data_dec.rd_ok) begin
            st_nxt.data_ack = 1'h1;
            st_nxt.data_fault = 1'h1;
            st_nxt.data_rdata = 8'h00;
            st_nxt.state = ST_RESP;
          end else if (data_dec.region == RG_PMC) begin
            pmc_wr = data_we;
            st_nxt.data_ack = 1'h1;
            st_nxt.data_rdata = data_we ? 8'h00 : pmc_value;
            st_nxt.state = ST_RESP;
          end else begin
            st_nxt.mem_we = data_we;
            st_nxt = mmd_issue(st_nxt, data_dec.region, data_addr, data_dec.flash_off,
                               data_dec.ram_off);
          end
        end else if (fetch_req) begin
          st_nxt.src = SRC_FETCH;
          st_nxt.fetch_fault = 1'h0;
          if (!fetch_dec.fetch_ok) begin
            st_nxt.fetch_ack = 1'h1;
            st_nxt.fetch_fault = 1'h1;
            st_nxt.fetch_rdata = 8'h00;
            st_nxt.state = ST_RESP;
          end else begin
            st_nxt = mmd_issue(st_nxt, fetch_dec.region, fetch_addr, fetch_dec.flash_off,
                               fetch_dec.ram_off);
          end
        end
      end
      ST_WAIT: begin
        st_nxt.state = ST_CAPTURE;
      end
      ST_CAPTURE: begin
        if ((st_r.src == SRC_BOOT || st_r.src == SRC_TBL) && !st_r.hi) begin
          // Low byte from the even address, then fetch the odd one
          st_nxt.low = cap_byte;
          st_nxt.hi = 1'h1;
          st_nxt = mmd_issue(st_nxt, RG_VECTOR, st_r.addr + 20'h00001,
                             st_r.flash_addr + 14'h0001, 11'h000);
        end else begin
          st_nxt.state = ST_RESP;
          case (st_r.src)
            SRC_BOOT: begin
              st_nxt.boot_pc = {4'h0, cap_byte, st_r.low};
              st_nxt.boot_done = 1'h1;
              st_nxt.state = ST_IDLE;
            end
            SRC_TBL: begin
              st_nxt.tbl_target = {4'h0, cap_byte, st_r.low};
              st_nxt.tbl_ack = 1'h1;
            end
            SRC_DATA: begin
              st_nxt.data_rdata = st_r.hi ? 8'h00 : cap_byte;
              st_nxt.data_ack = 1'h1;
            end
            default: begin
              st_nxt.fetch_rdata = cap_byte;
              st_nxt.fetch_ack = 1'h1;
            end
          endcase
        end
      end
      ST_RESP: begin
        st_nxt.state = ST_IDLE;
      end
      default: begin
        st_nxt.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= RESET_STATE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  assign fetch_ack = st_r.fetch_ack;
  assign fetch_fault = st_r.fetch_fault;
  assign fetch_rdata = st_r.fetch_rdata;
  assign data_ack = st_r.data_ack;
  assign data_fault = st_r.data_fault;
  assign data_rdata = st_r.data_rdata;
  assign tbl_ack = st_r.tbl_ack;
  assign tbl_fault = st_r.tbl_fault;
  assign tbl_target = st_r.tbl_target;
  assign boot_done = st_r.boot_done;
  assign boot_pc = st_r.boot_pc;
  assign flash_en = st_r.flash_en;
  assign flash_addr = st_r.flash_addr;
  assign ram_en = st_r.ram_en;
  assign ram_addr = st_r.ram_addr;
  assign gpr_sel = st_r.gpr_sel;
  assign gpr_bank = st_r.gpr_bank;
  assign sfr_en = st_r.sfr_en;
  assign sfr_addr = st_r.sfr_addr;
  assign mem_we = st_r.mem_we;
  assign mem_wdata = st_r.mem_wdata;
  assign mem_bit_op = st_r.mem_bit_op;
  assign mem_bit_idx = st_r.mem_bit_idx;

endmodule

// ### tb/mmd_map_chk.sv
`timescale 1ns/1ps
module mmd_map_chk #(
  parameter bit FLASH_LARGE = 1'h1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [19:0] fetch_addr,
  input wire logic data_req,
  input wire logic data_we,
  input wire logic data_bit_op,
  input wire logic [2:0] data_bit_idx,
  input wire logic [19:0] data_addr,
  input wire logic [7:0] data_wdata,
  input wire logic fetch_ack,
  input wire logic fetch_fault,
  input wire logic data_ack,
  input wire logic data_fault,
  input wire logic tbl_ack,
  input wire logic tbl_fault,
  input wire logic [19:0] tbl_target,
  input wire logic flash_en,
  input wire logic [13:0] flash_addr,
  input wire logic ram_en,
  input wire logic [10:0] ram_addr,
  input wire logic gpr_sel,
  input wire logic [1:0] gpr_bank,
  input wire logic sfr_en,
  input wire logic [7:0] sfr_addr,
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_bit_op,
  input wire logic [2:0] mem_bit_idx
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_fmir;
    fetch_ack && fetch_addr >= 20'hF0000 && fetch_addr < 20'hFF900 |-> fetch_fault;
  endproperty
  a_fmir: assert property (p_fmir) else $error("mirror fetch taken");
  property p_fgpr;
    fetch_ack && fetch_addr >= 20'hFFEE0 && fetch_addr < 20'hFFF00 |-> fetch_fault;
  endproperty
  a_fgpr: assert property (p_fgpr) else $error("bank fetch taken");
  property p_wr;
    data_ack && data_we && data_addr < 20'hFF900 |-> data_fault;
  endproperty
  a_wr: assert property (p_wr) else $error("flash or mirror write taken");
  property p_size;
    data_ack && !data_we && data_addr inside {[20'h02000:20'h03FFF]}
      |-> data_fault == !FLASH_LARGE;
  endproperty
  a_size: assert property (p_size) else $error("flash size wrong");
  property p_boot;
    $fell(rst) |-> ##[0:4] (flash_en && flash_addr == 14'h0000);
  endproperty
  a_boot: assert property (p_boot) else $error("reset vector not read");
  property p_thi;
    tbl_ack && !tbl_fault |-> tbl_target[19:16] == 4'h0;
  endproperty
  a_thi: assert property (p_thi) else $error("table target above 64K");
  property p_ram;
    ram_en && data_req |-> ram_addr == 11'(data_addr - 20'hFF900);
  endproperty
  a_ram: assert property (p_ram) else $error("ram offset wrong");
  property p_gpr;
    ram_en && data_req && data_addr >= 20'hFFEE0 |-> gpr_sel && gpr_bank == data_addr[4:3];
  endproperty
  a_gpr: assert property (p_gpr) else $error("bank decode wrong");
  property p_sfr;
    sfr_en && data_req |-> data_addr >= 20'hFFF00 && sfr_addr == data_addr[7:0];
  endproperty
  a_sfr: assert property (p_sfr) else $error("register decode wrong");
  property p_mir;
    flash_en && data_req && data_addr >= 20'hF0000 |-> flash_addr == data_addr[13:0];
  endproperty
  a_mir: assert property (p_mir) else $error("mirror offset wrong");
  property p_fwd;
    (ram_en || sfr_en) && data_req |-> mem_we == data_we && mem_wdata == data_wdata
      && mem_bit_op == data_bit_op && mem_bit_idx == data_bit_idx;
  endproperty
  a_fwd: assert property (p_fwd) else $error("write forwarding wrong");
endmodule

bind mmd_memory_map_decoder mmd_map_chk #(.FLASH_LARGE(FLASH_LARGE)) u_mmd_map_chk (.*);

// ### tb/mmd_mem_model.sv
`timescale 1ns/1ps
module mmd_mem_model (
  input wire logic core_clk,
  input wire logic flash_en,
  input wire logic [13:0] flash_addr,
  input wire logic ram_en,
  input wire logic [10:0] ram_addr,
  input wire logic sfr_en,
  input wire logic [7:0] sfr_addr,
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] flash_rdata,
  output logic [7:0] ram_rdata,
  output logic [7:0] sfr_rdata
);
  logic [7:0] mem [2048];
  // Sync read; a bus not enabled toggles so stale data never matches
  always_ff @(posedge core_clk) begin
    flash_rdata <= flash_en ? flash_addr[7:0] ^ {2'h0, flash_addr[13:8]} ^ 8'hA5 : ~flash_rdata;
    ram_rdata <= ram_en ? mem[ram_addr] : ~ram_rdata;
    sfr_rdata <= sfr_en ? sfr_addr ^ 8'h3C : ~sfr_rdata;
    if (ram_en && mem_we) mem[ram_addr] <= mem_wdata;
  end
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
  import mmd_pkg::*;
  logic core_clk, rst, fetch_req, data_req, data_we, data_bit_op, tbl_req, flash_mirror_control;
  logic fetch_ack, fetch_fault, data_ack, data_fault, tbl_ack, tbl_fault, boot_done;
  logic flash_en, ram_en, gpr_sel, sfr_en, mem_we, mem_bit_op;
  logic [19:0] fetch_addr, data_addr, tbl_target, boot_pc, a;
  logic [7:0] tbl_addr, data_wdata, flash_rdata, ram_rdata, sfr_rdata;
  logic [7:0] fetch_rdata, data_rdata, sfr_addr, mem_wdata;
  logic [13:0] flash_addr;
  logic [10:0] ram_addr;
  logic [2:0] data_bit_idx, mem_bit_idx;
  logic [1:0] gpr_bank;
  logic [7:0] ram [int];
  int fail_count = 0, tests_run = 0, cyc = 0;
  logic [19:0] rd_tab [14] = '{20'h00000, 20'h0007F, 20'h000BF, 20'h000C3, 20'h000CD,
    20'h03FFF, 20'h04000, 20'hF0400, 20'hF0800, 20'hF3FFF, 20'hF4000, 20'hFF8FF,
    20'hFFF10, 20'hFFEE8};
  logic [19:0] f_tab [6] = '{20'h00100, 20'hF0100, 20'hFF900, 20'hFFEE8, 20'hFFF10, 20'h04000};
  logic [19:0] t_tab [7] = '{20'h00, 20'h04, 20'h7E, 20'h80, 20'hBE, 20'hC0, 20'h05};

  mmd_memory_map_decoder #(.FLASH_LARGE(1'h1)) u_mmd_memory_map_decoder (.*);
  mmd_mem_model u_mmd_mem_model (.*);

  initial begin
    core_clk = 0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      conclude();
    end
  end

  function automatic logic [7:0] fb(input logic [13:0] x);
    return x[7:0] ^ {2'h0, x[13:8]} ^ 8'hA5;
  endfunction
  task automatic cmp(input logic [19:0] g, input logic [19:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------
  // Reference map
  // ----------------------------------------
  task automatic mdl(input int k, input logic [19:0] x, input logic w, input logic [7:0] d,
      input logic b, input logic [2:0] i, output logic f, output logic [19:0] r);
    f = 1;
    r = 0;
    if (k == 2) begin
      if (x <= 'hBF && !x[0]) begin
        f = 0;
        r = {4'h0, fb(x[13:0] + 14'h1), fb(x[13:0])};
      end
    end else if (x <= 'h3FFF) begin
      f = w;
      r = w ? 0 : fb(x[13:0]);
    end else if (x >= 'hF0800 && x < 'hFF900) begin
      if (!w && k == 1 && !flash_mirror_control && x - 'hF0000 <= 'h3FFF) begin
        f = 0;
        r = fb(x[13:0]);
      end
    end else if (x >= 'hFF900 && x < 'hFFF00) begin
      if (k == 1 || x < 'hFFEE0) begin
        f = 0;
        if (w) ram[x] = d;
        else r = ram[x];
      end
    end else if (x == 'hFFFFE && k == 1) begin
      f = 0;
      if (w && (!b || i == 0)) flash_mirror_control = d[0];
      r = w ? 0 : flash_mirror_control;
    end else if (k == 1 && x >= 'hFFF00) begin
      f = 0;
      r = w ? 0 : x[7:0] ^ 8'h3C;
    end
  endtask

  task automatic go(input int k, input logic [19:0] x, input logic w = 0,
      input logic [7:0] d = 8'h00, input logic b = 0, input logic [2:0] i = 3'h0);
    logic ef, f;
    logic [19:0] er, r;
    int n;
    mdl(k, x, w, d, b, i, ef, er);
    fetch_addr = x;
    data_addr = x;
    tbl_addr = x[7:0];
    data_we = w;
    data_wdata = d;
    data_bit_op = b;
    data_bit_idx = i;
    fetch_req = k == 0;
    data_req = k == 1;
    tbl_req = k == 2;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (!(fetch_ack || data_ack || tbl_ack) && n < 12);
    f = k == 0 ? fetch_fault : k == 1 ? data_fault : tbl_fault;
    r = k == 0 ? {12'h0, fetch_rdata} : k == 1 ? {12'h0, data_rdata} : tbl_target;
    fetch_req = 0;
    data_req = 0;
    tbl_req = 0;
    cmp({18'h0, n >= 12, f}, {19'h0, ef});
    if (!ef) cmp(r, er);
    @(posedge core_clk);
    #1;
  endtask

  task automatic do_rst();
    rst = 1;
    repeat (4) @(posedge core_clk);
    #1;
    rst = 0;
    flash_mirror_control = 0;
    for (int j = 0; j < 20 && boot_done !== 1'b1; j++) begin
      @(posedge core_clk);
      #1;
    end
    cmp(boot_pc, {4'h0, fb(14'h1), fb(14'h0)});
  endtask

  initial begin
    {rst, fetch_req, data_req, data_we, data_bit_op, tbl_req} = 6'h20;
    {fetch_addr, data_addr, tbl_addr, data_wdata, data_bit_idx} = 59'h0;
    void'($urandom(32'h0F56));
    do_rst();
    go(1, 20'hFFFFE);
    $display("boot test done");
    go(1, 20'hFF900, 1, 8'h5A);
    go(1, 20'hFFEE8, 1, 8'hC3);
    go(1, 20'h00100, 1, 8'h11);
    go(1, 20'hF0100, 1, 8'h22);
    repeat (30) begin
      a = 20'hFF900 + 20'($urandom_range(0, 'h5FF));
      go(1, a, 1, 8'($urandom));
      go(1, a);
    end
    $display("write test done");
    foreach (rd_tab[j]) go(1, rd_tab[j]);
    repeat (30) go(1, 20'hF0800 + 20'($urandom_range(0, 'h37FF)));
    $display("read test done");
    foreach (f_tab[j]) go(0, f_tab[j]);
    foreach (t_tab[j]) go(2, t_tab[j]);
    $display("fetch and table test done");
    go(1, 20'hFFFFE, 1, 8'hFF);
    go(1, 20'hFFFFE);
    go(1, 20'hF0100);
    go(1, 20'hFFFFE, 1, 8'h00, 1, 3'h3);
    go(1, 20'hFFFFE);
    go(1, 20'hFFFFE, 1, 8'h00, 1, 3'h0);
    go(1, 20'hF0100);
    go(1, 20'hFFFFE, 1, 8'h01);
    do_rst();
    go(1, 20'hFFFFE);
    $display("mirror control test done");
    conclude();
  end
endmodule
